//--- hdl/enable_latch_bank_link_fault.sv
// three enable latches on a shared bus, link fault flags, apb status and interrupt
//
// The APB register port and the address map were chosen for this implementation.
`default_nettype none

// What this block does
// - output strobe high: each shared bus bit directly enables its mapped serial driver
// - a low driver bit powers that serial driver down
// - output strobe falling captures the bus and holds it until strobe rises
// - device reset low clears the driver latch, disabling every serial driver
// - receive power strobe high: bus bits drive receive pll and analog enables
// - high receive power enable keeps channel active, low puts it in power saving
// - receive power strobe falling captures bus into receive power latch and holds it
// - device reset low clears the receive power latch, disabling both channels
// - self-test strobe high: low bit selects pattern generate or compare
// - high self-test bit means normal traffic; self-test enables are active low
// - self-test strobe falling captures bus into self-test latch until strobe rises
// - device reset while self-test latch closed clears it, disabling all self-test
// - each receive channel flag is active low OR of four fault conditions
// - flag asserts when received data frequency is out of range
// - flag asserts when received amplitude is below expected levels
// - flag asserts when received transition density is too low
// - flag asserts while the receive channel is disabled
module enable_latch_bank_link_fault
	import enable_latch_pkg::*;
(
	// apb clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// host latch pins, asynchronous
	input  wire logic              driver_enable_latch_strobe,
	input  wire logic              rx_power_latch_strobe,
	input  wire logic              selftest_latch_strobe,
	input  wire logic [BUS_W-1:0]  shared_enable_bus,
	input  wire logic              device_reset_n,
	// fault detectors per receive channel, asynchronous
	input  wire logic [CHAN_N-1:0] freq_fault,
	input  wire logic [CHAN_N-1:0] amp_fault,
	input  wire logic [CHAN_N-1:0] density_fault,
	// latched enables
	output logic      [BUS_W-1:0]  serial_output_driver_en,
	output logic      [CHAN_N-1:0] rx_power_en,
	output logic      [CHAN_N-1:0] tx_selftest_n,
	output logic      [CHAN_N-1:0] rx_selftest_n,
	// link fault flags
	output logic                   link_fault_flag_chan_a_n,
	output logic                   link_fault_flag_chan_b_n,
	// interrupt
	output logic                   irq
);

	// pin synchronisers; host holds the bus steady around strobes, so per-bit skew is harmless
	logic [BUS_W-1:0]  bus_m_q, bus_s_q;
	logic [2:0]        stb_m_q, stb_s_q, stb_prev_q;
	logic              rst_m_q, rst_s_q, rst_prev_q;
	fault_src_t [CHAN_N-1:0] flt_m_q, flt_s_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_m_q <= '0;
			bus_s_q <= '0;
			stb_m_q <= '0;
			stb_s_q <= '0;
			rst_m_q <= 1'b1;
			rst_s_q <= 1'b1;
			flt_m_q <= '0;
			flt_s_q <= '0;
		end
		else
		begin
			bus_m_q <= shared_enable_bus;
			bus_s_q <= bus_m_q;
			stb_m_q <= {selftest_latch_strobe, rx_power_latch_strobe, driver_enable_latch_strobe};
			stb_s_q <= stb_m_q;
			rst_m_q <= device_reset_n;
			rst_s_q <= rst_m_q;
			for (int c = 0; c < CHAN_N; c++)
			begin
				flt_m_q[c] <= '{freq: freq_fault[c], amp: amp_fault[c], density: density_fault[c]};
			end
			flt_s_q <= flt_m_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stb_prev_q <= '0;
			rst_prev_q <= 1'b1;
		end
		else
		begin
			stb_prev_q <= stb_s_q;
			rst_prev_q <= rst_s_q;
		end
	end

	logic [2:0] stb_fall;
	logic       dev_rst_fall;
	assign stb_fall     = stb_prev_q & ~stb_s_q;
	assign dev_rst_fall = rst_prev_q & ~rst_s_q;

	// the three latches: transparent while strobe high, value at the fall is kept
	logic [BUS_W-1:0] drv_latch_q, rxp_latch_q, bist_latch_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drv_latch_q <= DRIVER_LATCH_RST;
		else if (!rst_s_q)
			drv_latch_q <= DRIVER_LATCH_RST;
		else if (stb_s_q[0])
			drv_latch_q <= bus_s_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rxp_latch_q <= RX_POWER_LATCH_RST;
		else if (!rst_s_q)
			rxp_latch_q <= RX_POWER_LATCH_RST;
		else if (stb_s_q[1])
			rxp_latch_q <= bus_s_q;
	end

	// reset only acts on the self-test latch while it is closed; an open latch keeps following the bus
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bist_latch_q <= SELFTEST_LATCH_RST;
		else if (stb_s_q[2])
			bist_latch_q <= bus_s_q;
		else if (!rst_s_q)
			bist_latch_q <= SELFTEST_LATCH_RST;
	end

	// registered enables, mapped through one table
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_output_driver_en <= DRIVER_LATCH_RST;
			rx_power_en             <= '0;
			tx_selftest_n           <= '1;
			rx_selftest_n           <= '1;
		end
		else
		begin
			serial_output_driver_en <= drv_latch_q;
			rx_power_en             <= {rxp_latch_q[RX_POWER_BIT_B], rxp_latch_q[RX_POWER_BIT_A]};
			tx_selftest_n           <= {bist_latch_q[TX_SELFTEST_BIT_B], bist_latch_q[TX_SELFTEST_BIT_A]};
			rx_selftest_n           <= {bist_latch_q[RX_SELFTEST_BIT_B], bist_latch_q[RX_SELFTEST_BIT_A]};
		end
	end

	// link fault per channel
	logic [CHAN_N-1:0] fault_q, fault_prev_q;

	generate
		for (genvar c = 0; c < CHAN_N; c++)
		begin : g_fault
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					fault_q[c] <= 1'b1;
				else
					fault_q[c] <= flt_s_q[c].freq
					            | flt_s_q[c].amp
					            | flt_s_q[c].density
					            | ~rx_power_en[c];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fault_prev_q <= '1;
		else
			fault_prev_q <= fault_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_fault_flag_chan_a_n <= 1'b0;
			link_fault_flag_chan_b_n <= 1'b0;
		end
		else
		begin
			link_fault_flag_chan_a_n <= ~fault_q[0];
			link_fault_flag_chan_b_n <= ~fault_q[1];
		end
	end

	// apb slave: one wait state, answer registered
	logic       acc_go, wr_go;
	logic       addr_ok;
	assign acc_go  = psel & penable & pready;
	assign wr_go   = acc_go & pwrite;
	assign addr_ok = (paddr == LATCH_STATUS_OFS) | (paddr == INT_STATUS_OFS)
	               | (paddr == INT_MASK_OFS) | (paddr == FAULT_STATUS_OFS);

	logic [EVT_W-1:0] int_status_q, int_mask_q, evt;

	assign evt = {~fault_q & fault_prev_q, fault_q & ~fault_prev_q, dev_rst_fall, stb_fall};

	// a new event in the clearing cycle stays set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_status_q <= '0;
		else if (wr_go && paddr == INT_STATUS_OFS && !pslverr)
			int_status_q <= (int_status_q & ~pwdata[EVT_W-1:0]) | evt;
		else
			int_status_q <= int_status_q | evt;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_mask_q <= INT_MASK_RST;
		else if (wr_go && paddr == INT_MASK_OFS && !pslverr)
			int_mask_q <= pwdata[EVT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(int_status_q & int_mask_q);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok;
			prdata  <= '0;
			if (psel && penable && !pready && !pwrite)
			begin
				case (paddr)
					LATCH_STATUS_OFS: prdata <= {20'h00000, bist_latch_q, rxp_latch_q, drv_latch_q};
					INT_STATUS_OFS:   prdata <= {24'h000000, int_status_q};
					INT_MASK_OFS:     prdata <= {24'h000000, int_mask_q};
					FAULT_STATUS_OFS: prdata <= {24'h000000, flt_s_q, fault_q};
					default:          prdata <= '0;
				endcase
			end
		end
	end

endmodule // enable_latch_bank_link_fault
`default_nettype wire

//--- hdl/enable_latch_pkg.sv
// constants for the enable latch bank and link fault block
`default_nettype none
package enable_latch_pkg;

	localparam int BUS_W  = 4;
	localparam int CHAN_N = 2;
	localparam int EVT_W  = 8;

	// apb register byte offsets
	localparam logic [7:0] LATCH_STATUS_OFS = 8'h00;
	localparam logic [7:0] INT_STATUS_OFS   = 8'h04;
	localparam logic [7:0] INT_MASK_OFS     = 8'h08;
	localparam logic [7:0] FAULT_STATUS_OFS = 8'h0C;

	// values after reset
	localparam logic [BUS_W-1:0]  DRIVER_LATCH_RST   = 4'h0;
	localparam logic [BUS_W-1:0]  RX_POWER_LATCH_RST = 4'h0;
	localparam logic [BUS_W-1:0]  SELFTEST_LATCH_RST = 4'hF;
	localparam logic [EVT_W-1:0]  INT_MASK_RST       = 8'h00;

	// bit mapping of the shared enable bus
	// drivers: bit0 out a1, bit1 out a2, bit2 out b1, bit3 out b2
	localparam int RX_POWER_BIT_A  = 0;
	localparam int RX_POWER_BIT_B  = 2;
	localparam int TX_SELFTEST_BIT_A = 0;
	localparam int RX_SELFTEST_BIT_A = 1;
	localparam int TX_SELFTEST_BIT_B = 2;
	localparam int RX_SELFTEST_BIT_B = 3;

	// interrupt event positions
	localparam int EVT_DRIVER_CAPTURE   = 0;
	localparam int EVT_RX_POWER_CAPTURE = 1;
	localparam int EVT_SELFTEST_CAPTURE = 2;
	localparam int EVT_DEVICE_RESET     = 3;
	localparam int EVT_FAULT_SET_A      = 4;
	localparam int EVT_FAULT_CLR_A      = 6;

	// link fault sources per channel
	typedef struct packed {
		logic freq;
		logic amp;
		logic density;
	} fault_src_t;

endpackage : enable_latch_pkg
`default_nettype wire

//--- tb/enable_latch_props.sv
// assertions on the enable latch bank ports
`default_nettype none
module enable_latch_props
	import enable_latch_pkg::*;
(
	input wire logic pclk, presetn, psel, penable, pready, device_reset_n,
	input wire logic driver_enable_latch_strobe, rx_power_latch_strobe, selftest_latch_strobe,
	input wire logic link_fault_flag_chan_a_n, link_fault_flag_chan_b_n,
	input wire logic [BUS_W-1:0] shared_enable_bus, serial_output_driver_en,
	input wire logic [CHAN_N-1:0] freq_fault, amp_fault, density_fault, rx_power_en, tx_selftest_n, rx_selftest_n
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [3:0] b = shared_enable_bus;
	wire logic [3:0] st = {rx_selftest_n, tx_selftest_n};
	wire logic [7:0] src = {freq_fault, amp_fault, density_fault, rx_power_en};
	wire logic [1:0] flt = freq_fault | amp_fault | density_fault | ~rx_power_en;
	wire logic ds = driver_enable_latch_strobe;
	wire logic rs = rx_power_latch_strobe;
	wire logic ss = selftest_latch_strobe;
	wire logic dr = device_reset_n;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// six settled cycles cover the two sync flops, the latch and the output register
	a_drv_follow: assert property ((ds && dr && $stable(b))[*6]
		|-> serial_output_driver_en == b) else $error("driver enables off bus");
	a_rx_follow: assert property ((rs && dr && $stable(b))[*6]
		|-> rx_power_en == {b[RX_POWER_BIT_B], b[RX_POWER_BIT_A]}) else $error("rx power off bus");
	a_st_follow: assert property ((ss && $stable(b))[*6]
		|-> st == {b[3], b[1], b[2], b[0]}) else $error("self-test off bus");
	a_latch_hold: assert property ((!ds && !rs && !ss && dr)[*6]
		|-> $stable({serial_output_driver_en, rx_power_en, st})) else $error("closed latch moved");
	a_devrst_clear: assert property ((!dr)[*6]
		|-> serial_output_driver_en == 4'h0 && rx_power_en == 2'h0) else $error("device reset ignored");
	a_st_reset: assert property ((!dr && !ss)[*6] |-> st == 4'hF) else $error("self-test not cleared");
	a_link_fault: assert property ($stable(src)[*6]
		|-> {link_fault_flag_chan_b_n, link_fault_flag_chan_a_n} == ~flt) else $error("fault flag wrong");
	a_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready after access");
endmodule // enable_latch_props
bind enable_latch_bank_link_fault enable_latch_props props_i (.*);
`default_nettype wire

//--- tb/host_latch_model.sv
// host logic model driving the latch strobes and the shared enable bus
`default_nettype none
module host_latch_model
	import enable_latch_pkg::*;
(
	input  wire logic             pclk,
	output logic      [2:0]       strobe,
	output logic      [BUS_W-1:0] bus
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		strobe = 3'h0;
		bus = 4'hF;
	end
	// one strobe at a time; bus held well past the fall, then inverted as released
	task automatic load(input int sel, input logic [BUS_W-1:0] val);
		@(posedge pclk);
		bus <= val;
		strobe[sel] <= 1'b1;
		repeat (8) @(posedge pclk);
		strobe[sel] <= 1'b0;
		repeat (8) @(posedge pclk);
		bus <= ~val;
	endtask
endmodule // host_latch_model
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the enable latch bank with apb status and interrupt
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import enable_latch_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, device_reset_n, irq, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] s;
	logic [3:0] bus, drv, v [3];
	logic [1:0] ff, af, df, rxp, txs, rxs;
	wire logic [1:0] fl;
	int fail_count = 0, compares = 0, seed = 32'hc508;
	enable_latch_bank_link_fault dut (.*, .driver_enable_latch_strobe(s[0]), .rx_power_latch_strobe(s[1]),
		.selftest_latch_strobe(s[2]), .shared_enable_bus(bus), .freq_fault(ff), .amp_fault(af), .density_fault(df),
		.serial_output_driver_en(drv), .rx_power_en(rxp), .tx_selftest_n(txs), .rx_selftest_n(rxs),
		.link_fault_flag_chan_a_n(fl[0]), .link_fault_flag_chan_b_n(fl[1]));
	host_latch_model host (.pclk, .strobe(s), .bus);
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	function automatic logic [1:0] flag_exp(input logic [1:0] f, input logic [3:0] rb);
		return ~(f | ~{rb[RX_POWER_BIT_B], rb[RX_POWER_BIT_A]});
	endfunction
	task automatic conclude();
		$display("counts: %0d bad of %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
		// a slave that never answers ends the run here with the verdict
		if (n == 20)
		begin
			fail_count++;
			conclude();
		end
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, ff, af, df} = '0;
		device_reset_n = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 4; i++)
		begin
			foreach (v[k])
			begin
				v[k] = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
				host.load(k, v[k]);
			end
			chk(drv, v[0]);
			chk(rxp, {v[1][RX_POWER_BIT_B], v[1][RX_POWER_BIT_A]});
			chk({rxs, txs}, {v[2][3], v[2][1], v[2][2], v[2][0]});
			chk(fl, flag_exp(2'h0, v[1]));
			apb(1'b0, LATCH_STATUS_OFS, 32'h0);
			chk(rd, {20'h0, v[2], v[1], v[0]});
		end
		$display("latch test done");
		host.load(1, 4'h5);
		for (int i = 0; i < 9; i++)
		begin
			{ff, af, df} <= (i < 6) ? 6'h01 << i : 6'($random(seed));
			repeat (8) @(posedge pclk);
			chk(fl, flag_exp(ff | af | df, 4'h5));
		end
		$display("fault test done");
		host.load(0, 4'hF);
		host.load(2, 4'h0);
		device_reset_n <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({rxs, txs, rxp, drv}, 32'h000003C0);
		device_reset_n <= 1'b1;
		$display("device reset test done");
		apb(1'b1, INT_MASK_OFS, 32'h000000FF);
		@(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, INT_MASK_OFS, 32'h0);
		chk(rd, 32'h000000FF);
		apb(1'b1, INT_STATUS_OFS, 32'hFFFFFFFF);
		apb(1'b0, INT_STATUS_OFS, 32'h0);
		chk(rd, 32'h0);
		chk(irq, 1'b0);
		host.load(0, 4'h3);
		chk(irq, 1'b1);
		apb(1'b0, INT_STATUS_OFS, 32'h0);
		chk(rd, 32'h1 << EVT_DRIVER_CAPTURE);
		apb(1'b1, INT_MASK_OFS, 32'h0);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, 8'h10, 32'h0);
		chk(e, 1'b1);
		// receive power was cleared by the device reset, so both channels report a fault
		apb(1'b0, FAULT_STATUS_OFS, 32'h0);
		chk(rd, {24'h0, ff[1], af[1], df[1], ff[0], af[0], df[0], 2'b11});
		chk(fl, flag_exp(ff | af | df, 4'h0));
		$display("interrupt test done");
		conclude();
	end
endmodule // tb
`default_nettype wire
